// File: rtl/ept_pkg.sv
// package: execute phase timing constants and carrier types
package ept_pkg;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned REG_ADDR_W  = 5;
   localparam int unsigned MEM_ADDR_W  = 32;
   localparam int unsigned FP_STAT_W   = 8;
   localparam int unsigned PHASE_W     = 3;
   // execute phases, counted from phase one
   localparam logic [2:0] PH_ONE   = 3'h1;
   localparam logic [2:0] PH_TWO   = 3'h2;
   localparam logic [2:0] PH_THREE = 3'h3;
   localparam logic [2:0] PH_FOUR  = 3'h4;
   localparam logic [2:0] PH_FIVE  = 3'h5;
   localparam logic [2:0] PH_IDLE  = 3'h0;
   // branch target: fetch/decode phases from generate to first execute
   localparam logic [2:0] BRANCH_DELAY_SLOTS = 3'h5;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      EPT_SINGLE,
      EPT_MULTIPLY,
      EPT_STORE,
      EPT_LOAD,
      EPT_BRANCH,
      EPT_DOUBLE_TWO,
      EPT_FLOAT_FOUR
   } ept_class_t;

   typedef enum logic [1:0] {
      EPT_UNIT_LOGICAL,
      EPT_UNIT_SHIFT,
      EPT_UNIT_MULTIPLY,
      EPT_UNIT_DATA
   } ept_unit_t;

   // one issued instruction entering execute phase one
   typedef struct packed {
      logic                  valid;
      ept_class_t            iclass;
      ept_unit_t             unit;
      logic                  side_b;
      logic [REG_ADDR_W-1:0] dst;
      logic [REG_ADDR_W-1:0] base_register;
      logic [DATA_W-1:0]     first_source_port;
      logic [DATA_W-1:0]     second_source_port;
      logic [DATA_W-1:0]     result_low;
      logic [DATA_W-1:0]     result_high;
      logic [DATA_W-1:0]     base_next;
      logic [MEM_ADDR_W-1:0] mem_addr;
      logic [FP_STAT_W-1:0]  fp_status;
   } ept_issue_t;

   // register file write port
   typedef struct packed {
      logic                  valid;
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     data;
   } ept_reg_wr_t;

   // data memory request
   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [MEM_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     data;
   } ept_mem_req_t;
endpackage : ept_pkg

// File: rtl/ept_execute_phase_timing.sv
// module: execute phase scheduler for each instruction class
`timescale 1ns/1ps
`default_nettype none
// Operation
// - single-cycle ops read, compute and write their result in phase one with no delay slot.
// - a 16x16 multiply starts in phase one on the multiply unit and writes its result in phase two.
// - a store computes its address in phase one, sends address and data in phase two, memory writes in phase three.
// - a store writes its updated base register in phase one and counts as zero delay slots.
// - a load one cycle ahead of a store to the same word returns the old contents.
// - a store one cycle ahead of a load to the same word makes the load return the new value.
// - a load and store issued together read the old value first then write the new one in the same phase.
// - a load modifies its pointer, sends address, reads memory, takes data in, and writes its destination over five phases.
// - load data is seen after four delay slots while the pointer update is seen at once.
// - since store writes and load reads both sit in phase three, a later load sees the stored value.
// - a branch reads its target in one phase on the second shift unit and the target runs after five delay slots.
// - when a branch is in phase one its target packet is in program address generate that same cycle.
// - two-cycle double ops on a shift unit read both halves in phase one and write low then high halves.
// - two-cycle double ops write the auxiliary floating status in phase one.
// - four-cycle float ops on multiply or logical unit read in phase one and write in phase four.
// - four-cycle float ops write multiply or adder floating status by unit in phase four.
module ept_execute_phase_timing (
   input  wire logic                 clock,
   input  wire logic                 rst_b,
   input  wire ept_pkg::ept_issue_t  issue,
   input  wire logic [31:0]          mem_rd_data,
   output logic                      issue_ok,
   output ept_pkg::ept_reg_wr_t      reg_wr_a,
   output ept_pkg::ept_reg_wr_t      reg_wr_b,
   output ept_pkg::ept_mem_req_t     mem_req,
   output logic                      mem_rd_strobe,
   output logic [31:0]               mem_rd_addr,
   output logic                      fetch_redirect,
   output logic [31:0]               fetch_target,
   output logic [7:0]                fp_aux_status_reg,
   output logic [7:0]                fp_multiply_status_reg,
   output logic [7:0]                fp_adder_status_reg
);
   localparam int unsigned NSLOT = 5;

   ept_pkg::ept_issue_t slot_reg  [NSLOT];
   logic [2:0]          phase_reg [NSLOT];

   // phase-one register writes of the issue and later-phase writes from the slots
   ept_pkg::ept_reg_wr_t e1_wr_next;
   ept_pkg::ept_reg_wr_t late_wr_next;

   // load data held from the edge ending phase four
   logic [31:0]          load_data_reg;

   function automatic logic at_phase(input ept_pkg::ept_issue_t s, input logic [2:0] ph,
                                     input ept_pkg::ept_class_t c, input logic [2:0] want);
      at_phase = s.valid && (s.iclass == c) && (ph == want);
   endfunction : at_phase

   // shared pipeline slots for all classes: slot k holds the instruction in phase k+2
   genvar g;
   generate
      for (g = 0; g < NSLOT; g++)
      begin : g_slot
         if (g == 0)
         begin : g_head
            // head slot takes the issue as it leaves phase one
            always_ff @(posedge clock or negedge rst_b)
            begin
               if (!rst_b)
               begin
                  slot_reg[g]  <= '0;
                  phase_reg[g] <= ept_pkg::PH_IDLE;
               end
               else
               begin
                  slot_reg[g]  <= issue;
                  phase_reg[g] <= issue.valid ? ept_pkg::PH_TWO : ept_pkg::PH_IDLE;
               end
            end
         end
         else
         begin : g_tail
            // later slots advance one phase per cycle
            always_ff @(posedge clock or negedge rst_b)
            begin
               if (!rst_b)
               begin
                  slot_reg[g]  <= '0;
                  phase_reg[g] <= ept_pkg::PH_IDLE;
               end
               else
               begin
                  slot_reg[g]  <= slot_reg[g-1];
                  phase_reg[g] <= (phase_reg[g-1] == ept_pkg::PH_IDLE) ? ept_pkg::PH_IDLE
                                  : 3'(phase_reg[g-1] + 3'h1);
               end
            end
         end
      end
   endgenerate

   always_comb
   begin
      e1_wr_next = '0;
      if (issue.valid)
      begin
         case (issue.iclass)
            ept_pkg::EPT_SINGLE:
               e1_wr_next = '{1'b1, issue.dst, issue.result_low};
            ept_pkg::EPT_STORE,
            ept_pkg::EPT_LOAD:
               e1_wr_next = '{1'b1, issue.base_register, issue.base_next};
            ept_pkg::EPT_DOUBLE_TWO:
               e1_wr_next = '{1'b1, issue.dst, issue.result_low};
            default:
               e1_wr_next = '0;
         endcase
      end
   end

   // later-phase destination writes; on a same-cycle collision multiply wins, then double high half, then float, then load
   always_comb
   begin
      late_wr_next = '0;
      if (at_phase(slot_reg[0], phase_reg[0], ept_pkg::EPT_MULTIPLY, ept_pkg::PH_TWO))
         late_wr_next = '{1'b1, slot_reg[0].dst, slot_reg[0].result_low};
      else if (at_phase(slot_reg[0], phase_reg[0], ept_pkg::EPT_DOUBLE_TWO, ept_pkg::PH_TWO))
         late_wr_next = '{1'b1, slot_reg[0].dst + 5'h1, slot_reg[0].result_high};
      else if (at_phase(slot_reg[2], phase_reg[2], ept_pkg::EPT_FLOAT_FOUR, ept_pkg::PH_FOUR))
         late_wr_next = '{1'b1, slot_reg[2].dst, slot_reg[2].result_low};
      else if (at_phase(slot_reg[3], phase_reg[3], ept_pkg::EPT_LOAD, ept_pkg::PH_FIVE))
         late_wr_next = '{1'b1, slot_reg[3].dst, load_data_reg};
   end

   // phase four: data arrives at the core boundary, one cycle after the read strobe
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         load_data_reg <= ept_pkg::WORD_RESET;
      end
      else if (at_phase(slot_reg[2], phase_reg[2], ept_pkg::EPT_LOAD, ept_pkg::PH_FOUR))
      begin
         load_data_reg <= mem_rd_data;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_wr_a <= '0;
         reg_wr_b <= '0;
      end
      else
      begin
         reg_wr_a <= e1_wr_next;
         reg_wr_b <= late_wr_next;
      end
   end

   // memory side: phase two sends, phase three accesses; reads ordered ahead of writes
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_req       <= '0;
         mem_rd_strobe <= 1'b0;
         mem_rd_addr   <= ept_pkg::WORD_RESET;
      end
      else
      begin
         mem_req       <= '0;
         mem_rd_strobe <= 1'b0;
         if (at_phase(slot_reg[0], phase_reg[0], ept_pkg::EPT_STORE, ept_pkg::PH_TWO))
            mem_req <= '{1'b1, 1'b1, slot_reg[0].mem_addr, slot_reg[0].first_source_port};
         if (at_phase(slot_reg[0], phase_reg[0], ept_pkg::EPT_LOAD, ept_pkg::PH_TWO))
         begin
            // controller samples read before write within the same phase
            mem_rd_strobe <= 1'b1;
            mem_rd_addr   <= slot_reg[0].mem_addr;
         end
      end
   end

   // branch: target read in phase one, fetch redirected at once
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fetch_redirect <= 1'b0;
         fetch_target   <= ept_pkg::WORD_RESET;
      end
      else
      begin
         fetch_redirect <= issue.valid && issue.iclass == ept_pkg::EPT_BRANCH
                           && issue.unit == ept_pkg::EPT_UNIT_SHIFT && issue.side_b;
         fetch_target   <= issue.second_source_port;
      end
   end

   // floating status registers
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fp_aux_status_reg      <= '0;
         fp_multiply_status_reg <= '0;
         fp_adder_status_reg    <= '0;
      end
      else
      begin
         if (issue.valid && issue.iclass == ept_pkg::EPT_DOUBLE_TWO)
            fp_aux_status_reg <= fp_aux_status_reg | issue.fp_status;
         if (at_phase(slot_reg[2], phase_reg[2], ept_pkg::EPT_FLOAT_FOUR, ept_pkg::PH_FOUR))
         begin
            if (slot_reg[2].unit == ept_pkg::EPT_UNIT_MULTIPLY)
               fp_multiply_status_reg <= fp_multiply_status_reg | slot_reg[2].fp_status;
            else
               fp_adder_status_reg <= fp_adder_status_reg | slot_reg[2].fp_status;
         end
      end
   end

   // unit legality check for the issue
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         issue_ok <= 1'b0;
      else
      begin
         case (issue.iclass)
            ept_pkg::EPT_MULTIPLY:
            begin
               issue_ok <= issue.unit == ept_pkg::EPT_UNIT_MULTIPLY;
            end
            ept_pkg::EPT_STORE,
            ept_pkg::EPT_LOAD:
            begin
               issue_ok <= issue.unit == ept_pkg::EPT_UNIT_DATA;
            end
            ept_pkg::EPT_BRANCH:
            begin
               issue_ok <= issue.unit == ept_pkg::EPT_UNIT_SHIFT && issue.side_b;
            end
            ept_pkg::EPT_DOUBLE_TWO:
            begin
               issue_ok <= issue.unit == ept_pkg::EPT_UNIT_SHIFT;
            end
            ept_pkg::EPT_FLOAT_FOUR:
            begin
               issue_ok <= issue.unit == ept_pkg::EPT_UNIT_MULTIPLY
                           || issue.unit == ept_pkg::EPT_UNIT_LOGICAL;
            end
            default:
            begin
               // single-cycle ops may run on any unit
               issue_ok <= 1'b1;
            end
         endcase
      end
   end
endmodule : ept_execute_phase_timing
`default_nettype wire

// File: dv/ept_properties.sv
// checker: execute phase timing properties
`timescale 1ns/1ps
`default_nettype none
module ept_chk (
   input wire logic                  clock,
   input wire logic                  rst_b,
   input wire ept_pkg::ept_issue_t   issue,
   input wire logic [31:0]           mem_rd_data,
   input wire logic                  issue_ok,
   input wire ept_pkg::ept_reg_wr_t  reg_wr_a,
   input wire ept_pkg::ept_reg_wr_t  reg_wr_b,
   input wire ept_pkg::ept_mem_req_t mem_req,
   input wire logic                  mem_rd_strobe,
   input wire logic [31:0]           mem_rd_addr,
   input wire logic                  fetch_redirect,
   input wire logic [31:0]           fetch_target,
   input wire logic [7:0]            fp_aux_status_reg,
   input wire logic [7:0]            fp_multiply_status_reg,
   input wire logic [7:0]            fp_adder_status_reg
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire logic is_s  = issue.valid && issue.iclass == ept_pkg::EPT_SINGLE;
   wire logic is_m  = issue.valid && issue.iclass == ept_pkg::EPT_MULTIPLY;
   wire logic is_st = issue.valid && issue.iclass == ept_pkg::EPT_STORE;
   wire logic is_l  = issue.valid && issue.iclass == ept_pkg::EPT_LOAD;
   wire logic is_b  = issue.valid && issue.iclass == ept_pkg::EPT_BRANCH;
   wire logic is_d  = issue.valid && issue.iclass == ept_pkg::EPT_DOUBLE_TWO;
   wire logic is_fm = issue.valid && issue.iclass == ept_pkg::EPT_FLOAT_FOUR && issue.unit == ept_pkg::EPT_UNIT_MULTIPLY;
   wire logic is_f  = issue.valid && issue.iclass == ept_pkg::EPT_FLOAT_FOUR;
   single_write_a: assert property (is_s |=> reg_wr_a.valid && reg_wr_a.data == $past(issue.result_low))
      else $error("single result not written in phase one");
   multiply_write_a: assert property (is_m |-> ##2 reg_wr_b.valid && reg_wr_b.data == $past(issue.result_low, 2))
      else $error("multiply result not written in phase two");
   store_timing_a: assert property (is_st |=> reg_wr_a.addr == $past(issue.base_register) ##1 mem_req.valid && mem_req.write)
      else $error("store base update or request misplaced");
   load_timing_a: assert property (is_l |-> ##2 mem_rd_strobe ##3 reg_wr_b.valid && reg_wr_b.data == $past(mem_rd_data, 2))
      else $error("load phases misplaced");
   branch_redirect_a: assert property (is_b && issue.side_b |=> fetch_redirect)
      else $error("branch redirect missing");
   double_halves_a: assert property (is_d |=> reg_wr_a.valid ##1 reg_wr_b.valid && reg_wr_b.addr == $past(issue.dst, 2) + 5'h1)
      else $error("double halves misplaced");
   aux_status_a: assert property (is_d |=> (fp_aux_status_reg & $past(issue.fp_status)) == $past(issue.fp_status))
      else $error("auxiliary status not set in phase one");
   float_write_a: assert property (is_f |-> ##4 reg_wr_b.valid && reg_wr_b.data == $past(issue.result_low, 4))
      else $error("float result not written in phase four");
   mul_status_a: assert property (is_fm |-> ##3 $stable(fp_multiply_status_reg) ##1 (fp_multiply_status_reg & $past(issue.fp_status, 4)) == $past(issue.fp_status, 4))
      else $error("multiply status not set in phase four");
   cover property (is_l);
   cover property (is_d);
   cover property (is_fm);
endmodule : ept_chk
bind ept_execute_phase_timing ept_chk chk_u (.clock, .rst_b, .issue, .mem_rd_data, .issue_ok, .reg_wr_a, .reg_wr_b,
   .mem_req, .mem_rd_strobe, .mem_rd_addr, .fetch_redirect, .fetch_target, .fp_aux_status_reg,
   .fp_multiply_status_reg, .fp_adder_status_reg);
`default_nettype wire

// File: dv/ept_mem_model.sv
// partner: data memory controller model
`timescale 1ns/1ps
`default_nettype none
module ept_mem_model (
   input wire logic                  clock,
   input wire ept_pkg::ept_mem_req_t mem_req,
   input wire logic                  mem_rd_strobe,
   input wire logic [31:0]           mem_rd_addr,
   output logic [31:0]               mem_rd_data
);
   logic [31:0] mem [16];
   initial
   begin
      mem_rd_data = 32'h0;
      for (int i = 0; i < 16; i++) mem[i] = 32'hA500_0000 + i;
   end
   // read takes old contents before a same-edge write lands; data inverts every cycle while the read strobe is low
   always @(posedge clock)
   begin
      mem_rd_data <= mem_rd_strobe ? mem[mem_rd_addr[3:0]] : ~mem_rd_data;
      if (mem_req.valid && mem_req.write) mem[mem_req.addr[3:0]] <= mem_req.data;
   end
endmodule : ept_mem_model
`default_nettype wire

// File: dv/tb.sv
// testbench: execute phase timing
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                  clock = 1'b0;
   logic                  rst_b = 1'b0;
   ept_pkg::ept_issue_t   issue = '0;
   logic [31:0]           rd, ra, ft, shadow [16];
   logic                  ok, rs, fr;
   logic [7:0]            sx, sm, sa;
   ept_pkg::ept_reg_wr_t  wa, wb;
   ept_pkg::ept_mem_req_t mq;
   int                    n_errors = 0, samples_checked = 0, cycles = 0;
   always #4 clock = ~clock;
   ept_execute_phase_timing dut_u (.clock(clock), .rst_b(rst_b), .issue(issue), .mem_rd_data(rd), .issue_ok(ok),
      .reg_wr_a(wa), .reg_wr_b(wb), .mem_req(mq), .mem_rd_strobe(rs), .mem_rd_addr(ra), .fetch_redirect(fr),
      .fetch_target(ft), .fp_aux_status_reg(sx), .fp_multiply_status_reg(sm), .fp_adder_status_reg(sa));
   ept_mem_model mem_u (.clock(clock), .mem_req(mq), .mem_rd_strobe(rs), .mem_rd_addr(ra), .mem_rd_data(rd));
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   function automatic int late(ept_pkg::ept_class_t c);
      case (c)
         ept_pkg::EPT_MULTIPLY, ept_pkg::EPT_DOUBLE_TWO: return 2;
         ept_pkg::EPT_FLOAT_FOUR: return 4;
         ept_pkg::EPT_LOAD: return 5;
         default: return 0;
      endcase
   endfunction : late
   // store data is placed on every source field so any store data path sees it
   task automatic put(ept_pkg::ept_class_t c, logic [3:0] a, logic [31:0] d);
      @(negedge clock);
      issue = '{valid: 1'b1, iclass: c, unit: ept_pkg::ept_unit_t'(2'($urandom)), side_b: 1'b1, dst: 5'($urandom),
         base_register: 5'($urandom), first_source_port: d, second_source_port: d, result_low: d, result_high: ~d,
         base_next: $urandom, mem_addr: {28'h0, a}, fp_status: 8'($urandom)};
      case (c)
         ept_pkg::EPT_MULTIPLY: issue.unit = ept_pkg::EPT_UNIT_MULTIPLY;
         ept_pkg::EPT_FLOAT_FOUR: issue.unit = $urandom_range(1) ? ept_pkg::EPT_UNIT_MULTIPLY : ept_pkg::EPT_UNIT_LOGICAL;
         ept_pkg::EPT_STORE, ept_pkg::EPT_LOAD: issue.unit = ept_pkg::EPT_UNIT_DATA;
         ept_pkg::EPT_BRANCH, ept_pkg::EPT_DOUBLE_TWO: issue.unit = ept_pkg::EPT_UNIT_SHIFT;
         default: ;
      endcase
      if (c == ept_pkg::EPT_STORE) shadow[a] = d;
   endtask : put
   task automatic send(ept_pkg::ept_class_t c, logic [3:0] a, logic [31:0] d);
      logic [31:0] e;
      e = (c == ept_pkg::EPT_LOAD) ? shadow[a] : (c == ept_pkg::EPT_DOUBLE_TWO) ? ~d : d;
      put(c, a, d);
      for (int k = 1; k < 7; k++)
      begin
         @(negedge clock);
         issue.valid = 1'b0;
         chk("phase one write", 32'(k == 1 && c inside {ept_pkg::EPT_SINGLE, ept_pkg::EPT_STORE, ept_pkg::EPT_LOAD,
            ept_pkg::EPT_DOUBLE_TWO}), 32'(wa.valid));
         chk("late write", 32'(k == late(c)), 32'(wb.valid));
         if (k == late(c)) chk("late data", e, wb.data);
         chk("store request", 32'(k == 2 && c == ept_pkg::EPT_STORE), 32'(mq.valid));
         chk("load read", 32'(k == 2 && c == ept_pkg::EPT_LOAD), 32'(rs));
         chk("redirect", 32'(k == 1 && c == ept_pkg::EPT_BRANCH), 32'(fr));
         if (k == 1) chk("pairing legal", 32'h1, 32'(ok));
         if (k == 1 && c == ept_pkg::EPT_BRANCH) chk("branch target", d, ft);
         if (k == 2 && c == ept_pkg::EPT_STORE) chk("store data", d, mq.data);
         if (k == 2 && c == ept_pkg::EPT_LOAD) chk("load address", {28'h0, a}, ra);
         if (k == 1 && c == ept_pkg::EPT_DOUBLE_TWO) chk("aux status", 32'(issue.fp_status), 32'(sx & issue.fp_status));
         if (k == 4 && c == ept_pkg::EPT_FLOAT_FOUR)
            chk("float status", 32'(issue.fp_status),
               32'((issue.unit == ept_pkg::EPT_UNIT_MULTIPLY ? sm : sa) & issue.fp_status));
      end
   endtask : send
   task automatic pair(logic st_first, logic [3:0] a, logic [31:0] d);
      logic [31:0] e;
      e = st_first ? d : shadow[a];
      put(st_first ? ept_pkg::EPT_STORE : ept_pkg::EPT_LOAD, a, d);
      put(st_first ? ept_pkg::EPT_LOAD : ept_pkg::EPT_STORE, a, d);
      @(negedge clock);
      issue.valid = 1'b0;
      for (int k = 0; k < 8 && wb.valid !== 1'b1; k++) @(negedge clock);
      chk("ordered load data", e, wb.data);
      repeat (3) @(negedge clock);
   endtask : pair
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 1500)
      begin
         n_errors++;
         test_done();
      end
   end
   initial
   begin
      void'($urandom(62177));
      for (int i = 0; i < 16; i++) shadow[i] = 32'hA500_0000 + i;
      repeat (5) @(posedge clock);
      @(negedge clock) rst_b = 1'b1;
      put(ept_pkg::EPT_SINGLE, 4'h0, 32'h0000_0011);
      put(ept_pkg::EPT_SINGLE, 4'h0, 32'h0000_0022);
      chk("back to back first", 32'h0000_0011, wa.data);
      @(negedge clock) issue.valid = 1'b0;
      chk("back to back second", 32'h0000_0022, wa.data);
      for (int i = 0; i < 7; i++) send(ept_pkg::ept_class_t'(i), 4'h3, $urandom);
      pair(1'b1, 4'h5, 32'hC0DE_0001);
      pair(1'b0, 4'h5, 32'hC0DE_0002);
      repeat (40) send(ept_pkg::ept_class_t'($urandom_range(6)), 4'($urandom), $urandom);
      test_done();
   end
endmodule : tb
`default_nettype wire
